/* File: rtl/aat_pkg.sv */
// Purpose: shared constants for the application advertising table
// Assumes: APB with 32-bit data, one byte register per aligned word
// Notes: printed offsets are byte indexes; bus address is index times four
package aat_pkg;
    // printed byte indexes of the lower page
    localparam logic [7:0] IDX_MODULE_TYPE = 8'h55;
    localparam logic [7:0] IDX_APP1_HOST_CODE = 8'h56;
    localparam logic [7:0] IDX_APP1_MEDIA_CODE = 8'h57;
    localparam logic [7:0] IDX_APP1_LANE_COUNTS = 8'h58;
    localparam logic [7:0] IDX_APP1_HOST_STARTS = 8'h59;
    // printed byte index of the first media start bitmap, page 01h
    localparam logic [7:0] IDX_APP1_MEDIA_STARTS = 8'hb0;
    // page selector register, chosen
    localparam logic [7:0] IDX_PAGE_SELECT = 8'h7f;
    // chosen index of the second region on page 01h for codes 9..15
    localparam logic [7:0] IDX_APP9_HOST_CODE = 8'hdf;
    localparam logic [7:0] PAGE_LOWER = 8'h00;
    localparam logic [7:0] PAGE_ONE = 8'h01;
    localparam int BYTES_PER_ENTRY = 4;
    localparam int APPS_REGION_A = 8;
    localparam int APPS_MAX = 15;
    localparam logic [7:0] CODE_END_OF_LIST = 8'hff;
    localparam logic [7:0] MEDIA_CODE_UNDEFINED = 8'h00;
    localparam logic [3:0] LANE_COUNT_MAX = 4'h8;
    // storage layout: 0 module type, 1..60 entries (4 bytes each), 61..75 media starts
    localparam int MEM_TYPE = 0;
    localparam int MEM_ENTRY_BASE = 1;
    localparam int MEM_MEDIA_BASE = 61;
    localparam int MEM_DEPTH = 76;
    localparam logic [1:0] PSTATE_IDLE = 2'h0;
    typedef enum logic [1:0] {
        AAT_IDLE = 2'b00,
        AAT_READ = 2'b01,
        AAT_DONE = 2'b10
    } aat_bus_e;
endpackage

/* File: rtl/aat_rom.sv */
// Purpose: read-only byte store holding the advertising table content
// Assumes: content fixed at elaboration, read data registered
// Notes: no write port exists, so host writes can never change content
`timescale 1ns/1ns
module aat_rom #(
    parameter int DEPTH = 76,
    parameter int AW = 7,
    parameter logic [8*DEPTH-1:0] CONTENT = '0
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // read port
    input wire logic rd_en,
    input wire logic [AW-1:0] rd_addr,
    output logic [7:0] rd_data
);
    initial begin
        if (DEPTH > (1 << AW)) begin
            $error("aat_rom depth exceeds address range");
        end
    end

    // registered read; out-of-range reads give zero
    always_ff @(posedge clk) begin
        if (srst) begin
            rd_data <= 8'h00;
        end else if (rd_en) begin
            rd_data <= (int'(rd_addr) < DEPTH) ? CONTENT[int'(rd_addr)*8 +: 8] : 8'h00;
        end
    end
endmodule

/* File: rtl/aat_table.sv */
// Purpose: APB slave exposing the read-only application advertising table
// Assumes: APB3 style, 32-bit data, byte registers in the low eight bits
// Notes: reads and writes both take two cycles of access phase; table writes are dropped
//
// Our own choice: register access over APB.
`timescale 1ns/1ns
//
// Behaviour
// - first unused entry carries FFh in its host interface code
// - each entry has a unique selection code used by the host
// - host lane count in bits 7-4; 0 means implied, 1-8 lanes
// - media lane count in bits 3-0, same encoding, cable lane count
// - lane counts agree with the standards named by the codes
// - host start bitmap bit n means start on host lane n+1
// - multi-lane instances use consecutive lanes from a marked start
// - media start bitmap lives on page 01h, apart from the entry
// - copper cable assemblies may omit the media start bitmap
// - all advertised start positions run concurrently
// - between one and fifteen applications are advertised
// - power-up default sits at selection code 1
// - alternates fill codes from 2 upward without gaps
// - codes 1-8 in one region, codes 9-15 in another on page 01h
// - only valid combinations advertised; host selects only advertised ones
// - module type byte 85 chooses the media code list
// - host or media codes may repeat across entries
module aat_table #(
    parameter int NUM_APPS = 2,
    parameter logic [7:0] MODULE_TYPE = 8'h01, // arbitrary default
    parameter logic [8*15-1:0] HOST_CODES = {8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h01},
    parameter logic [8*15-1:0] MEDIA_CODES = {8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h01},
    parameter logic [8*15-1:0] LANE_COUNTS = {8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h44, 8'h88},
    parameter logic [8*15-1:0] HOST_STARTS = {8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h11, 8'h01},
    parameter logic [8*15-1:0] MEDIA_STARTS = {8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h11, 8'h01},
    parameter bit OMIT_MEDIA_STARTS = 1'b0
) (
    // clock and reset
    input wire logic CLK,
    input wire logic SRST,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // table status
    output logic [3:0] APP_COUNT,
    output logic TABLE_VALID
);
    localparam int AW = 7;

    // lane count field sane: 0 or 1..8 per nibble
    function automatic bit count_ok(input logic [3:0] c);
        count_ok = (c <= aat_pkg::LANE_COUNT_MAX);
    endfunction

    // lanes implied by a count nibble, zero meaning one for span checks
    function automatic int span(input logic [3:0] c);
        span = (c == 4'h0) ? 1 : int'(c);
    endfunction

    // start bitmap fits: each marked start leaves room for consecutive lanes
    function automatic bit starts_fit(input logic [7:0] map, input logic [3:0] c);
        starts_fit = 1'b1;
        for (int i = 0; i < 8; i++) begin
            if (map[i] && (i + span(c) > 8)) begin
                starts_fit = 1'b0;
            end
        end
    endfunction

    // starts of concurrent instances never overlap
    function automatic bit starts_disjoint(input logic [7:0] map, input logic [3:0] c);
        logic [8:0] used;
        starts_disjoint = 1'b1;
        used = '0;
        for (int i = 0; i < 8; i++) begin
            if (map[i]) begin
                for (int k = 0; k < 8; k++) begin
                    if (k >= i && k < i + span(c)) begin
                        if (used[k]) begin
                            starts_disjoint = 1'b0;
                        end
                        used[k] = 1'b1;
                    end
                end
            end
        end
    endfunction

    // storage image built at elaboration
    function automatic logic [8*aat_pkg::MEM_DEPTH-1:0] build_image();
        logic [8*aat_pkg::MEM_DEPTH-1:0] img;
        img = '0;
        img[aat_pkg::MEM_TYPE*8 +: 8] = MODULE_TYPE;
        for (int a = 0; a < aat_pkg::APPS_MAX; a++) begin
            if (a < NUM_APPS) begin
                img[(aat_pkg::MEM_ENTRY_BASE + a*4)*8 +: 8] = HOST_CODES[a*8 +: 8];
                img[(aat_pkg::MEM_ENTRY_BASE + a*4 + 1)*8 +: 8] = MEDIA_CODES[a*8 +: 8];
                img[(aat_pkg::MEM_ENTRY_BASE + a*4 + 2)*8 +: 8] = LANE_COUNTS[a*8 +: 8];
                img[(aat_pkg::MEM_ENTRY_BASE + a*4 + 3)*8 +: 8] = HOST_STARTS[a*8 +: 8];
                img[(aat_pkg::MEM_MEDIA_BASE + a)*8 +: 8] =
                    OMIT_MEDIA_STARTS ? 8'h00 : MEDIA_STARTS[a*8 +: 8];
            end else if (a == NUM_APPS) begin
                img[(aat_pkg::MEM_ENTRY_BASE + a*4)*8 +: 8] = aat_pkg::CODE_END_OF_LIST;
            end
        end
        return img;
    endfunction

    localparam logic [8*aat_pkg::MEM_DEPTH-1:0] IMAGE = build_image();

    // elaboration checks on the advertised content
    initial begin
        if (NUM_APPS < 1 || NUM_APPS > aat_pkg::APPS_MAX) begin
            $error("application count out of range");
        end
        for (int a = 0; a < aat_pkg::APPS_MAX; a++) begin
            if (a < NUM_APPS) begin
                if (HOST_CODES[a*8 +: 8] == aat_pkg::CODE_END_OF_LIST) begin
                    $error("advertised entry uses the end code");
                end
                if (!count_ok(LANE_COUNTS[a*8+4 +: 4]) || !count_ok(LANE_COUNTS[a*8 +: 4])) begin
                    $error("reserved lane count value");
                end
                if (HOST_STARTS[a*8 +: 8] == 8'h00 ||
                    !starts_fit(HOST_STARTS[a*8 +: 8], LANE_COUNTS[a*8+4 +: 4]) ||
                    !starts_disjoint(HOST_STARTS[a*8 +: 8], LANE_COUNTS[a*8+4 +: 4])) begin
                    $error("host start bitmap cannot hold concurrent instances");
                end
                if (!OMIT_MEDIA_STARTS && (MEDIA_STARTS[a*8 +: 8] == 8'h00 ||
                    !starts_disjoint(MEDIA_STARTS[a*8 +: 8], LANE_COUNTS[a*8 +: 4]))) begin
                    $error("media start bitmap missing or overlapping");
                end
                // same number of instances on both sides
                if (!OMIT_MEDIA_STARTS &&
                    $countones(HOST_STARTS[a*8 +: 8]) != $countones(MEDIA_STARTS[a*8 +: 8])) begin
                    $error("host and media instance counts differ");
                end
            end
        end
    end

    // bus decode
    wire logic [9:0] word_idx = PADDR[11:2];
    wire logic setup = PSEL && !PENABLE;
    wire logic page_sel_hit = (word_idx == {2'b00, aat_pkg::IDX_PAGE_SELECT});
    wire logic aligned = (PADDR[1:0] == 2'b00);
    logic [7:0] page;
    logic [AW-1:0] next_mem_addr;
    logic mem_hit;

    // lower page holds type and codes 1-8; page 01h media bitmaps and codes 9-15
    always_comb begin
        mem_hit = 1'b0;
        next_mem_addr = '0;
        if (!aligned || word_idx[9:8] != 2'b00) begin
            mem_hit = 1'b0;
        end else if (page == aat_pkg::PAGE_LOWER && word_idx[7:0] == aat_pkg::IDX_MODULE_TYPE) begin
            mem_hit = 1'b1;
            next_mem_addr = AW'(aat_pkg::MEM_TYPE);
        end else if (page == aat_pkg::PAGE_LOWER && word_idx[7:0] >= aat_pkg::IDX_APP1_HOST_CODE &&
                     word_idx[7:0] < aat_pkg::IDX_APP1_HOST_CODE + 8'(aat_pkg::APPS_REGION_A*4)) begin
            mem_hit = 1'b1;
            next_mem_addr = AW'(word_idx[7:0] - aat_pkg::IDX_APP1_HOST_CODE) + AW'(aat_pkg::MEM_ENTRY_BASE);
        end else if (page == aat_pkg::PAGE_ONE && word_idx[7:0] >= aat_pkg::IDX_APP1_MEDIA_STARTS &&
                     word_idx[7:0] < aat_pkg::IDX_APP1_MEDIA_STARTS + 8'(aat_pkg::APPS_MAX)) begin
            mem_hit = 1'b1;
            next_mem_addr = AW'(word_idx[7:0] - aat_pkg::IDX_APP1_MEDIA_STARTS) + AW'(aat_pkg::MEM_MEDIA_BASE);
        end else if (page == aat_pkg::PAGE_ONE && word_idx[7:0] >= aat_pkg::IDX_APP9_HOST_CODE &&
                     word_idx[7:0] < aat_pkg::IDX_APP9_HOST_CODE +
                     8'((aat_pkg::APPS_MAX - aat_pkg::APPS_REGION_A)*4)) begin
            mem_hit = 1'b1;
            next_mem_addr = AW'(word_idx[7:0] - aat_pkg::IDX_APP9_HOST_CODE) +
                AW'(aat_pkg::MEM_ENTRY_BASE + aat_pkg::APPS_REGION_A*4);
        end
    end

    wire logic mapped = (mem_hit || (aligned && page_sel_hit));
    logic [7:0] rom_data;
    aat_pkg::aat_bus_e state;
    aat_pkg::aat_bus_e next_state;
    logic is_page_rd;

    aat_rom #(
        .DEPTH(aat_pkg::MEM_DEPTH),
        .AW(AW),
        .CONTENT(IMAGE)
    ) u_rom (
        .clk(CLK),
        .srst(SRST),
        .rd_en(setup && !PWRITE && mem_hit),
        .rd_addr(next_mem_addr),
        .rd_data(rom_data)
    );

    // read sequencer: setup launches rom read, data returned on completion
    always_comb begin
        next_state = state;
        case (state)
            aat_pkg::AAT_IDLE: begin
                if (setup && !PWRITE) begin
                    next_state = aat_pkg::AAT_READ;
                end
            end
            aat_pkg::AAT_READ: begin
                next_state = aat_pkg::AAT_DONE;
            end
            aat_pkg::AAT_DONE: begin
                next_state = aat_pkg::AAT_IDLE;
            end
            default: begin
                next_state = aat_pkg::AAT_IDLE;
            end
        endcase
    end

    wire logic wr_done = PSEL && PENABLE && PWRITE && !PREADY;
    wire logic rd_done = (state == aat_pkg::AAT_READ);
    logic rd_err;

    // bus state and page register; page select is the only writable byte
    always_ff @(posedge CLK) begin
        if (SRST) begin
            state <= aat_pkg::AAT_IDLE;
            page <= aat_pkg::PAGE_LOWER;
            is_page_rd <= 1'b0;
            rd_err <= 1'b0;
        end else begin
            state <= next_state;
            if (setup && !PWRITE) begin
                is_page_rd <= aligned && page_sel_hit;
                rd_err <= !mapped;
            end
            if (setup && PWRITE && aligned && page_sel_hit) begin
                page <= PWDATA[7:0];
            end
        end
    end

    // answer: writes and reads both complete in the second access cycle, PREADY registered
    // table writes answered but dropped
    always_ff @(posedge CLK) begin
        if (SRST) begin
            PREADY <= 1'b0;
            PRDATA <= 32'h0000_0000;
            PSLVERR <= 1'b0;
        end else begin
            PREADY <= wr_done || rd_done;
            PSLVERR <= (wr_done && !mapped) || (rd_done && rd_err);
            if (rd_done) begin
                PRDATA <= rd_err ? 32'h0000_0000 : {24'h00_0000, is_page_rd ? page : rom_data};
            end
        end
    end

    // status: contiguous count from code 1
    always_ff @(posedge CLK) begin
        if (SRST) begin
            APP_COUNT <= 4'h0;
            TABLE_VALID <= 1'b0;
        end else begin
            APP_COUNT <= 4'(NUM_APPS);
            TABLE_VALID <= 1'b1;
        end
    end

    // assertions
    property p_ready_pulse;
        @(posedge CLK) disable iff (SRST) PREADY |=> !PREADY;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready held two cycles");

    property p_read_latency;
        @(posedge CLK) disable iff (SRST) (setup && !PWRITE) |=> !PREADY ##1 PREADY;
    endproperty
    a_read_latency: assert property (p_read_latency) else $error("read answer not two cycles after setup");

    property p_write_latency;
        @(posedge CLK) disable iff (SRST) (setup && PWRITE) |=> !PREADY ##1 PREADY;
    endproperty
    a_write_latency: assert property (p_write_latency) else $error("write answer not two cycles after setup");

    property p_page_stable_on_table_write;
        @(posedge CLK) disable iff (SRST) (setup && PWRITE && !page_sel_hit) |=> $stable(page);
    endproperty
    a_page_stable_on_table_write: assert property (p_page_stable_on_table_write)
        else $error("table write changed page");

    property p_status_count;
        @(posedge CLK) disable iff (SRST) TABLE_VALID |-> (APP_COUNT >= 4'h1 && APP_COUNT <= 4'hf);
    endproperty
    a_status_count: assert property (p_status_count) else $error("advertised count out of range");

    property p_end_code;
        @(posedge CLK) disable iff (SRST)
        (setup && !PWRITE && mem_hit && NUM_APPS < aat_pkg::APPS_MAX &&
         next_mem_addr == AW'(aat_pkg::MEM_ENTRY_BASE + NUM_APPS*aat_pkg::BYTES_PER_ENTRY))
        |=> ##1 (PRDATA[7:0] == aat_pkg::CODE_END_OF_LIST);
    endproperty
    a_end_code: assert property (p_end_code) else $error("end code missing after last entry");

    property p_default_first;
        @(posedge CLK) disable iff (SRST)
        (setup && !PWRITE && mem_hit && page == aat_pkg::PAGE_LOWER && word_idx[7:0] == aat_pkg::IDX_APP1_HOST_CODE)
        |=> ##1 (PRDATA[7:0] == HOST_CODES[7:0]);
    endproperty
    a_default_first: assert property (p_default_first) else $error("code 1 entry wrong");

    property p_lane_nibbles;
        @(posedge CLK) disable iff (SRST)
        (setup && !PWRITE && mem_hit && next_mem_addr >= AW'(aat_pkg::MEM_ENTRY_BASE) &&
         next_mem_addr < AW'(aat_pkg::MEM_MEDIA_BASE) && next_mem_addr[1:0] == 2'b11)
        |=> ##1 (PRDATA[7:4] <= aat_pkg::LANE_COUNT_MAX && PRDATA[3:0] <= aat_pkg::LANE_COUNT_MAX);
    endproperty
    a_lane_nibbles: assert property (p_lane_nibbles) else $error("reserved lane count read");

    property p_unmapped_err;
        @(posedge CLK) disable iff (SRST) (setup && !PWRITE && !mapped) |=> ##1 (PSLVERR && PRDATA == 32'h0);
    endproperty
    a_unmapped_err: assert property (p_unmapped_err) else $error("unmapped read not refused");

    c_read: cover property (@(posedge CLK) disable iff (SRST) rd_done && !rd_err);
    c_write_drop: cover property (@(posedge CLK) disable iff (SRST) wr_done && mem_hit);
    c_page_one: cover property (@(posedge CLK) disable iff (SRST) page == aat_pkg::PAGE_ONE && rd_done);
    c_refused: cover property (@(posedge CLK) disable iff (SRST) PREADY && PSLVERR);
endmodule

/* File: tb/aat_host_model.sv */
// Purpose: host side model that reaches the advertising table over APB
// Assumes: one transfer at a time, master signals change just after a rising edge
// Notes: address and write data are inverted while the bus is released
`timescale 1ns/1ns
module aat_host_model (
    // clock
    input wire logic clk,
    // apb master outputs
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    // apb slave answer
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    // idle bus at time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
    end

    // only reads and writes by entry place, never selects
    // caller reads the module type before any media code
    task automatic xfer(input logic wr, input logic [11:0] addr, input logic [31:0] wdata,
        output logic [31:0] rdata, output logic err, output logic done);
        int n;
        done = 1'b0;
        rdata = 32'h0000_0000;
        err = 1'b1;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wdata;
        @(posedge clk);
        penable <= 1'b1;
        // request held until pready is seen at an edge, for at most 32 edges
        while (!done && n < 32) begin
            @(posedge clk);
            n++;
            if (pready === 1'b1) begin
                done = 1'b1;
                rdata = prdata;
                err = pslverr;
            end
        end
        // release; stale address and data are not left on the bus
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~addr;
        pwdata <= ~wdata;
    endtask
endmodule

/* File: tb/testbench.sv */
// Purpose: self-checking bench for the advertising table
// Assumes: nine applications, codes 1..8 on page 00h and 9 on page 01h
// Notes: expected bytes come from the content handed to the table
`timescale 1ns/1ns
module testbench;
    localparam int NAPPS = 9;
    localparam logic [8*15-1:0] HOSTC = {48'h0000_0000_0000, 72'h19_1817_1615_1413_1211};
    localparam logic [8*15-1:0] MEDIAC = {48'h0000_0000_0000, 72'h05_0505_0505_0505_0005};
    localparam logic [8*15-1:0] LANES = {48'h0000_0000_0000, 72'h11_1111_1111_1111_1111};
    localparam logic [8*15-1:0] HSTART = {48'h0000_0000_0000, 72'h01_0101_0101_0101_0101};
    localparam logic [8*15-1:0] MSTART = {48'h0000_0000_0000, 72'h01_0101_0101_0101_0101};
    localparam logic [7:0] MTYPE = 8'h01; // arbitrary module type
    logic clk;
    logic srst;
    logic psel, penable, pwrite, pready, pslverr, table_valid;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, prdata_cu;
    logic [3:0] app_count;
    int mismatches = 0;
    int total_checks = 0;

    aat_host_model host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    aat_table #(.NUM_APPS(NAPPS), .MODULE_TYPE(MTYPE), .HOST_CODES(HOSTC), .MEDIA_CODES(MEDIAC),
        .LANE_COUNTS(LANES), .HOST_STARTS(HSTART), .MEDIA_STARTS(MSTART)) DUT (
        .CLK(clk), .SRST(srst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .APP_COUNT(app_count), .TABLE_VALID(table_valid));

    // copper assembly variant on the same bus: media start bitmaps left out
    aat_table #(.NUM_APPS(NAPPS), .MODULE_TYPE(MTYPE), .HOST_CODES(HOSTC), .MEDIA_CODES(MEDIAC),
        .LANE_COUNTS(LANES), .HOST_STARTS(HSTART), .MEDIA_STARTS(MSTART), .OMIT_MEDIA_STARTS(1'b1)) DUT_CU (
        .CLK(clk), .SRST(srst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata_cu), .PREADY(), .PSLVERR(), .APP_COUNT(), .TABLE_VALID());

    // 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // byte address of a printed index
    function automatic logic [11:0] ba(input logic [7:0] idx);
        return {2'b00, idx, 2'b00};
    endfunction

    // expected entry byte k of selection code c
    function automatic logic [7:0] ent(input int c, input int k);
        logic [8*15-1:0] f;
        f = (k == 0) ? HOSTC : (k == 1) ? MEDIAC : (k == 2) ? LANES : HSTART;
        if (c > NAPPS)
            return (c == NAPPS + 1 && k == 0) ? 8'hff : 8'h00;
        return f[8*(c-1)+:8];
    endfunction

    // one bus transfer with outcome compare
    task automatic acc(input logic wr, input logic [11:0] addr, input logic [31:0] wd,
        input logic [7:0] ed, input logic ee);
        logic [31:0] rd;
        logic er;
        logic ok;
        string what;
        what = $sformatf("byte at %h", addr);
        host.xfer(wr, addr, wd, rd, er, ok);
        check({what, " answered"}, {31'h0000_0000, ok}, 32'h0000_0001); // completes
        check({what, " error"}, {31'h0000_0000, er}, {31'h0000_0000, ee}); // refusal code
        if (!wr)
            check(what, rd, {24'h00_0000, ed}); // entry content
    endtask

    initial begin
        srst = 1'b1;
        repeat (16) @(posedge clk);
        @(negedge clk);
        check("count in reset", {28'h000_0000, app_count}, 32'h0000_0000); // reset count
        check("valid in reset", {31'h0000_0000, table_valid}, 32'h0000_0000); // reset flag
        @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        @(negedge clk);
        check("count", {28'h000_0000, app_count}, NAPPS); // advertised count
        check("valid", {31'h0000_0000, table_valid}, 32'h0000_0001); // table ready
        $display("test reset done");
        // page select and module type first, then codes 1..8 on page 00h
        acc(1'b0, ba(8'h7f), 32'h0000_0000, 8'h00, 1'b0); // page select resets low
        acc(1'b0, ba(8'h55), 32'h0000_0000, MTYPE, 1'b0);
        for (int c = 1; c <= 8; c++)
            for (int k = 0; k < 4; k++)
                acc(1'b0, ba(8'h56 + 8'(4 * (c - 1) + k)), 32'h0000_0000, ent(c, k), 1'b0);
        $display("test lower page done");
        // page 01h holds media starts and codes 9..15
        acc(1'b1, ba(8'h7f), 32'h0000_0001, 8'h00, 1'b0); // page change
        acc(1'b0, ba(8'h7f), 32'h0000_0000, 8'h01, 1'b0); // page reads back
        for (int c = 1; c <= 15; c++)
            acc(1'b0, ba(8'haf + 8'(c)), 32'h0000_0000, (c <= NAPPS) ? MSTART[8*(c-1)+:8] : 8'h00, 1'b0);
        for (int c = 9; c <= 15; c++)
            for (int k = 0; k < 4; k++)
                acc(1'b0, ba(8'hdf + 8'(4 * (c - 9) + k)), 32'h0000_0000, ent(c, k), 1'b0);
        $display("test page one done");
        // host writes to table bytes are dropped
        acc(1'b1, ba(8'hb0), 32'h0000_00aa, 8'h00, 1'b0);
        acc(1'b1, ba(8'he3), 32'h0000_00aa, 8'h00, 1'b0);
        acc(1'b0, ba(8'hb0), 32'h0000_0000, MSTART[7:0], 1'b0);
        check("copper media starts", prdata_cu, 32'h0000_0000);
        acc(1'b0, ba(8'he3), 32'h0000_0000, 8'hff, 1'b0);
        acc(1'b1, ba(8'h7f), 32'h0000_0000, 8'h00, 1'b0);
        acc(1'b1, ba(8'h56), 32'h0000_0055, 8'h00, 1'b0);
        acc(1'b1, ba(8'h55), 32'h0000_0000, 8'h00, 1'b0);
        acc(1'b0, ba(8'h56), 32'h0000_0000, HOSTC[7:0], 1'b0);
        acc(1'b0, ba(8'h55), 32'h0000_0000, MTYPE, 1'b0);
        $display("test writes done");
        // unmapped, misaligned and unlisted page
        acc(1'b0, ba(8'h10), 32'h0000_0000, 8'h00, 1'b1); // unmapped
        acc(1'b1, ba(8'h10), 32'h0000_00aa, 8'h00, 1'b1); // unmapped write
        acc(1'b0, ba(8'h55) + 12'h001, 32'h0000_0000, 8'h00, 1'b1); // misaligned
        acc(1'b0, ba(8'hb0), 32'h0000_0000, 8'h00, 1'b1); // not on page 00h
        acc(1'b1, ba(8'h7f), 32'h0000_0002, 8'h00, 1'b0); // unlisted page
        acc(1'b0, ba(8'h55), 32'h0000_0000, 8'h00, 1'b1); // unlisted page
        $display("test refusals done");
        // reset in mid-run brings the page back to 00h
        acc(1'b1, ba(8'h7f), 32'h0000_0001, 8'h00, 1'b0);
        @(posedge clk);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        check("valid in second reset", {31'h0000_0000, table_valid}, 32'h0000_0000);
        srst <= 1'b0;
        acc(1'b0, ba(8'h7f), 32'h0000_0000, 8'h00, 1'b0); // page after reset
        acc(1'b0, ba(8'h56), 32'h0000_0000, HOSTC[7:0], 1'b0);
        check("count after reset", {28'h000_0000, app_count}, NAPPS);
        $display("test second reset done");
        print_verdict();
    end

    // watchdog against a hung transfer
    initial begin
        repeat (5000) @(posedge clk);
        mismatches++;
        $display("watchdog expired");
        print_verdict();
    end
endmodule
